// ==== hdl/pmqu_fifo.sv ====
// Purpose: Flip-flop FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty come from an occupancy count.
`timescale 1ns/1ns
`default_nettype none
module pmqu_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrIdx;
  logic [AW-1:0] rdIdx;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign inReady = (count != FULL_COUNT);
  assign outValid = (count != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = store[rdIdx];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrIdx <= '0;
      rdIdx <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrIdx <= wrIdx + 1'b1;
      end
      if (pop) begin
        rdIdx <= rdIdx + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          store[i] <= '0;
        end else if (push && wrIdx == AW'(i)) begin
          store[i] <= inData;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== hdl/pmqu_unit.sv ====
// Purpose: Messaging queue unit: queue ports, pointers, status and interrupts.
// Assumes: One local memory operation in flight; memory answers with memDone.
// Notes: Pointers include their list's region offset; address is base | pointer.
`timescale 1ns/1ns
`default_nettype none
module pmqu_unit (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic regAck,
  output logic regRetry,
  output logic [31:0] regRdata,
  output logic memReq,
  input wire logic memReady,
  output pmqu_pkg::pmqu_mem_cmd_s memCmd,
  input wire logic memDone,
  input wire logic [31:0] memRdata,
  output logic pciIrq,
  output logic localIrq,
  output logic localSystemErrorIrq,
  output logic portDecodeEnable,
  output logic pciBaseRegionZeroRemap
);
  logic [31:0] outPostMask;
  logic [5:0] queueCfg;
  logic [11:0] base;
  logic [7:0] control;
  logic [17:0] inFreeHead;
  logic [17:0] inFreeTail;
  logic [17:0] inPostHead;
  logic [17:0] inPostTail;
  logic [17:0] outFreeHead;
  logic [17:0] outFreeTail;
  logic [17:0] outPostHead;
  logic [17:0] outPostTail;
  pmqu_pkg::pmqu_op_e opState;
  logic pfInValid;
  logic pfOutValid;
  logic [31:0] pfInData;
  logic [31:0] pfOutData;

  logic [17:0] sizeMask;
  logic inFreeEmpty;
  logic inPostNotEmpty;
  logic outPostNotEmpty;
  logic outFreeFullAfter;
  logic enabled;
  logic portHit;
  logic portIn;
  logic idle;
  logic cmdReady;
  logic wrHit;
  logic popIn;
  logic popOut;
  logic portRetry;
  logic [31:0] portData;
  pmqu_pkg::pmqu_op_e issueOp;
  pmqu_pkg::pmqu_mem_cmd_s issueCmd;
  logic [31:0] next_rdata;

  function automatic logic [17:0] wrapInc(input logic [17:0] ptr, input logic [17:0] mask);
    wrapInc = (ptr & ~mask) | ((ptr + 18'h00001) & mask);
  endfunction

  function automatic logic [31:0] ptrWord(input logic [17:0] ptr, input logic [11:0] b);
    ptrWord = {b, ptr, 2'b00};
  endfunction

  always_comb begin
    case (queueCfg[pmqu_pkg::CFG_SIZE_HI:pmqu_pkg::CFG_SIZE_LO])
      pmqu_pkg::SIZE_4K: sizeMask = pmqu_pkg::MASK_4K;
      pmqu_pkg::SIZE_8K: sizeMask = pmqu_pkg::MASK_8K;
      pmqu_pkg::SIZE_16K: sizeMask = pmqu_pkg::MASK_16K;
      pmqu_pkg::SIZE_32K: sizeMask = pmqu_pkg::MASK_32K;
      pmqu_pkg::SIZE_64K: sizeMask = pmqu_pkg::MASK_64K;
      default: sizeMask = pmqu_pkg::MASK_4K;
    endcase
  end

  assign inFreeEmpty = (inFreeHead == inFreeTail);
  assign inPostNotEmpty = (inPostHead != inPostTail);
  assign outPostNotEmpty = (outPostHead != outPostTail);
  assign outFreeFullAfter = (wrapInc(wrapInc(outFreeHead, sizeMask), sizeMask) == outFreeTail);

  assign enabled = queueCfg[pmqu_pkg::CFG_ENABLE];
  assign wrHit = regReq && regWrite;
  assign portHit = regReq && control[pmqu_pkg::CTRL_DECODE] &&
                   (regAddr == pmqu_pkg::OFS_IN_PORT || regAddr == pmqu_pkg::OFS_OUT_PORT);
  assign portIn = (regAddr == pmqu_pkg::OFS_IN_PORT);
  assign idle = (opState == pmqu_pkg::OP_NONE) && cmdReady;

  // Port handling and choice of the single memory operation to start
  always_comb begin
    issueOp = pmqu_pkg::OP_NONE;
    portRetry = 1'b0;
    popIn = 1'b0;
    popOut = 1'b0;
    portData = pmqu_pkg::ALL_ONES;
    if (portHit && enabled) begin
      if (!idle) begin
        portRetry = 1'b1;
      end else if (regWrite) begin
        if (portIn) begin
          issueOp = pmqu_pkg::OP_IN_POST_WR;
        end else begin
          issueOp = pmqu_pkg::OP_OUT_FREE_WR;
        end
      end else if (portIn) begin
        if (inFreeEmpty) begin
          portData = pmqu_pkg::ALL_ONES;
        end else if (pfInValid) begin
          portData = pfInData;
          popIn = 1'b1;
        end else begin
          portRetry = 1'b1;
          if (idle) begin
            issueOp = pmqu_pkg::OP_IN_FREE_RD;
          end
        end
      end else begin
        if (!outPostNotEmpty) begin
          portData = pmqu_pkg::ALL_ONES;
        end else if (pfOutValid) begin
          portData = pfOutData;
          popOut = 1'b1;
        end else begin
          portRetry = 1'b1;
          if (idle) begin
            issueOp = pmqu_pkg::OP_OUT_POST_RD;
          end
        end
      end
    end else if (idle && enabled && !portHit) begin
      if (control[pmqu_pkg::CTRL_PF_OUT] && outPostNotEmpty && !pfOutValid) begin
        issueOp = pmqu_pkg::OP_OUT_POST_RD;
      end else if (control[pmqu_pkg::CTRL_PF_IN] && !inFreeEmpty && !pfInValid) begin
        issueOp = pmqu_pkg::OP_IN_FREE_RD;
      end
    end
  end

  always_comb begin
    issueCmd.write = 1'b0;
    issueCmd.spaceSel = control[pmqu_pkg::CTRL_SPACE];
    issueCmd.data = regWdata;
    issueCmd.addr = ptrWord(inFreeTail, base);
    case (issueOp)
      pmqu_pkg::OP_IN_POST_WR: begin
        issueCmd.write = 1'b1;
        issueCmd.addr = ptrWord(inPostHead, base);
      end
      pmqu_pkg::OP_OUT_FREE_WR: begin
        issueCmd.write = 1'b1;
        issueCmd.addr = ptrWord(outFreeHead, base);
      end
      pmqu_pkg::OP_OUT_POST_RD: issueCmd.addr = ptrWord(outPostTail, base);
      pmqu_pkg::OP_IN_FREE_RD: issueCmd.addr = ptrWord(inFreeTail, base);
      default: issueCmd.addr = ptrWord(inFreeTail, base);
    endcase
  end

  pmqu_fifo #(
    .WIDTH(pmqu_pkg::CMD_WIDTH),
    .DEPTH(pmqu_pkg::CMD_FIFO_DEPTH)
  ) u_cmd_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .inValid(issueOp != pmqu_pkg::OP_NONE),
    .inReady(cmdReady),
    .inData(issueCmd),
    .outValid(memReq),
    .outReady(memReady),
    .outData(memCmd)
  );

  // Operation in flight; cleared when memory reports completion
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      opState <= pmqu_pkg::OP_NONE;
    end else if (issueOp != pmqu_pkg::OP_NONE) begin
      opState <= issueOp;
    end else if (memDone) begin
      opState <= pmqu_pkg::OP_NONE;
    end
  end

  // Prefetch holding registers, dropped when software moves the tail
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pfInValid <= 1'b0;
      pfOutValid <= 1'b0;
      pfInData <= pmqu_pkg::RESET_VALUE;
      pfOutData <= pmqu_pkg::RESET_VALUE;
    end else begin
      if (memDone && opState == pmqu_pkg::OP_IN_FREE_RD) begin
        pfInValid <= 1'b1;
        pfInData <= memRdata;
      end else if (popIn || !enabled || (wrHit && regAddr == pmqu_pkg::OFS_IN_FREE_TAIL)) begin
        pfInValid <= 1'b0;
      end
      if (memDone && opState == pmqu_pkg::OP_OUT_POST_RD) begin
        pfOutValid <= 1'b1;
        pfOutData <= memRdata;
      end else if (popOut || !enabled || (wrHit && regAddr == pmqu_pkg::OFS_OUT_POST_TAIL)) begin
        pfOutValid <= 1'b0;
      end
    end
  end

  // Software-owned configuration registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      outPostMask <= pmqu_pkg::RESET_VALUE;
      queueCfg <= '0;
      base <= '0;
    end else if (wrHit) begin
      case (regAddr)
        pmqu_pkg::OFS_OUT_POST_MASK: outPostMask[pmqu_pkg::OUT_POST_BIT] <=
          regWdata[pmqu_pkg::OUT_POST_BIT];
        pmqu_pkg::OFS_CONFIG: queueCfg <= regWdata[5:0];
        pmqu_pkg::OFS_BASE: base <= regWdata[pmqu_pkg::BASE_HI:pmqu_pkg::BASE_LO];
        default: base <= base;
      endcase
    end
  end

  // Pointers kept by software alone
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      inFreeHead <= '0;
      inPostTail <= '0;
      outFreeTail <= '0;
      outPostHead <= '0;
    end else if (wrHit) begin
      case (regAddr)
        pmqu_pkg::OFS_IN_FREE_HEAD: inFreeHead <= regWdata[pmqu_pkg::PTR_HI:pmqu_pkg::PTR_LO];
        pmqu_pkg::OFS_IN_POST_TAIL: inPostTail <= regWdata[pmqu_pkg::PTR_HI:pmqu_pkg::PTR_LO];
        pmqu_pkg::OFS_OUT_FREE_TAIL: outFreeTail <= regWdata[pmqu_pkg::PTR_HI:pmqu_pkg::PTR_LO];
        pmqu_pkg::OFS_OUT_POST_HEAD: outPostHead <= regWdata[pmqu_pkg::PTR_HI:pmqu_pkg::PTR_LO];
        default: inFreeHead <= inFreeHead;
      endcase
    end
  end

  // Pointers the unit advances; hardware advance wins over a software write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      inFreeTail <= '0;
      inPostHead <= '0;
      outFreeHead <= '0;
      outPostTail <= '0;
    end else begin
      if (popIn) begin
        inFreeTail <= wrapInc(inFreeTail, sizeMask);
      end else if (wrHit && regAddr == pmqu_pkg::OFS_IN_FREE_TAIL) begin
        inFreeTail <= regWdata[pmqu_pkg::PTR_HI:pmqu_pkg::PTR_LO];
      end
      if (memDone && opState == pmqu_pkg::OP_IN_POST_WR) begin
        inPostHead <= wrapInc(inPostHead, sizeMask);
      end else if (wrHit && regAddr == pmqu_pkg::OFS_IN_POST_HEAD) begin
        inPostHead <= regWdata[pmqu_pkg::PTR_HI:pmqu_pkg::PTR_LO];
      end
      if (memDone && opState == pmqu_pkg::OP_OUT_FREE_WR) begin
        outFreeHead <= wrapInc(outFreeHead, sizeMask);
      end else if (wrHit && regAddr == pmqu_pkg::OFS_OUT_FREE_HEAD) begin
        outFreeHead <= regWdata[pmqu_pkg::PTR_HI:pmqu_pkg::PTR_LO];
      end
      if (popOut) begin
        outPostTail <= wrapInc(outPostTail, sizeMask);
      end else if (wrHit && regAddr == pmqu_pkg::OFS_OUT_POST_TAIL) begin
        outPostTail <= regWdata[pmqu_pkg::PTR_HI:pmqu_pkg::PTR_LO];
      end
    end
  end

  // Queue control: plain bits, overflow flag with set beating clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      control <= '0;
    end else begin
      if (wrHit && regAddr == pmqu_pkg::OFS_CONTROL) begin
        control[4:0] <= regWdata[4:0];
        control[pmqu_pkg::CTRL_OVF_MASK] <= regWdata[pmqu_pkg::CTRL_OVF_MASK];
      end
      if (memDone && opState == pmqu_pkg::OP_OUT_FREE_WR && outFreeFullAfter) begin
        control[pmqu_pkg::CTRL_OVF_STAT] <= 1'b1;
      end else if (wrHit && regAddr == pmqu_pkg::OFS_CONTROL &&
                   regWdata[pmqu_pkg::CTRL_OVF_STAT]) begin
        control[pmqu_pkg::CTRL_OVF_STAT] <= 1'b0;
      end
    end
  end

  always_comb begin
    next_rdata = pmqu_pkg::RESET_VALUE;
    case (regAddr)
      pmqu_pkg::OFS_OUT_POST_STATUS: next_rdata[pmqu_pkg::OUT_POST_BIT] = outPostNotEmpty;
      pmqu_pkg::OFS_OUT_POST_MASK: next_rdata[pmqu_pkg::OUT_POST_BIT] =
        outPostMask[pmqu_pkg::OUT_POST_BIT];
      pmqu_pkg::OFS_IN_PORT: next_rdata = (portHit && enabled) ? portData :
        (control[pmqu_pkg::CTRL_DECODE] ? pmqu_pkg::ALL_ONES : pmqu_pkg::RESET_VALUE);
      pmqu_pkg::OFS_OUT_PORT: next_rdata = (portHit && enabled) ? portData :
        (control[pmqu_pkg::CTRL_DECODE] ? pmqu_pkg::ALL_ONES : pmqu_pkg::RESET_VALUE);
      pmqu_pkg::OFS_CONFIG: next_rdata[5:0] = queueCfg;
      pmqu_pkg::OFS_BASE: next_rdata = {base, 20'h00000};
      pmqu_pkg::OFS_IN_FREE_HEAD: next_rdata = ptrWord(inFreeHead, base);
      pmqu_pkg::OFS_IN_FREE_TAIL: next_rdata = ptrWord(inFreeTail, base);
      pmqu_pkg::OFS_IN_POST_HEAD: next_rdata = ptrWord(inPostHead, base);
      pmqu_pkg::OFS_IN_POST_TAIL: next_rdata = ptrWord(inPostTail, base);
      pmqu_pkg::OFS_OUT_FREE_HEAD: next_rdata = ptrWord(outFreeHead, base);
      pmqu_pkg::OFS_OUT_FREE_TAIL: next_rdata = ptrWord(outFreeTail, base);
      pmqu_pkg::OFS_OUT_POST_HEAD: next_rdata = ptrWord(outPostHead, base);
      pmqu_pkg::OFS_OUT_POST_TAIL: next_rdata = ptrWord(outPostTail, base);
      pmqu_pkg::OFS_CONTROL: begin
        next_rdata[7:0] = control;
        next_rdata[pmqu_pkg::CTRL_IN_STAT] = inPostNotEmpty;
      end
      default: next_rdata = pmqu_pkg::RESET_VALUE;
    endcase
  end

  // Register port answer, one cycle after the request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regAck <= 1'b0;
      regRetry <= 1'b0;
      regRdata <= pmqu_pkg::RESET_VALUE;
    end else begin
      regAck <= regReq && !portRetry;
      regRetry <= regReq && portRetry;
      if (regReq && !regWrite) begin
        regRdata <= next_rdata;
      end
    end
  end

  // Interrupt and decode outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pciIrq <= 1'b0;
      localIrq <= 1'b0;
      localSystemErrorIrq <= 1'b0;
      portDecodeEnable <= 1'b0;
      pciBaseRegionZeroRemap <= 1'b0;
    end else begin
      pciIrq <= outPostNotEmpty && !outPostMask[pmqu_pkg::OUT_POST_BIT];
      localIrq <= inPostNotEmpty && !control[pmqu_pkg::CTRL_IN_MASK];
      localSystemErrorIrq <= control[pmqu_pkg::CTRL_OVF_STAT] &&
                             !control[pmqu_pkg::CTRL_OVF_MASK];
      portDecodeEnable <= control[pmqu_pkg::CTRL_DECODE];
      pciBaseRegionZeroRemap <= control[pmqu_pkg::CTRL_DECODE];
    end
  end
endmodule
`default_nettype wire

// ==== shared/pmqu_pkg.sv ====
// Purpose: Constants, types and register map of the PCI message queue unit.
// Assumes: One clock, registers reached over a simple request/acknowledge port.
// Notes: Queue pointers hold word offsets in bits 19:2; base bits 31:20.
// How it works
// - Outbound post status bit tracks non-empty list
// - Outbound post mask bit blocks PCI interrupt
// - Inbound port write stores into inbound post list
// - Retry port accesses until write finishes
// - Local interrupt while inbound post not empty
// - Inbound port read pops inbound free list
// - Outbound port write stores into outbound free
// - Outbound free full raises local system error
// - Outbound port read pops outbound post list
// - PCI interrupt while outbound post not empty
// - Disabled queue discards writes, reads all ones
// - Config bits 5:1 select one-hot FIFO size
// - Device advances its four pointers modulo size
// - Decode enable maps ports and base region
// - Control bit 1 selects local space
// - Prefetch bits fetch from non-empty lists
// - Inbound post status bit, mask blocks interrupt
// - Overflow flag sticky, write one clears
package pmqu_pkg;

  localparam logic [7:0] OFS_OUT_POST_STATUS = 8'h30;
  localparam logic [7:0] OFS_OUT_POST_MASK = 8'h34;
  localparam logic [7:0] OFS_IN_PORT = 8'h40;
  localparam logic [7:0] OFS_OUT_PORT = 8'h44;
  localparam logic [7:0] OFS_CONFIG = 8'hc0;
  localparam logic [7:0] OFS_BASE = 8'hc4;
  localparam logic [7:0] OFS_IN_FREE_HEAD = 8'hc8;
  localparam logic [7:0] OFS_IN_FREE_TAIL = 8'hcc;
  localparam logic [7:0] OFS_IN_POST_HEAD = 8'hd0;
  localparam logic [7:0] OFS_IN_POST_TAIL = 8'hd4;
  localparam logic [7:0] OFS_OUT_FREE_HEAD = 8'hd8;
  localparam logic [7:0] OFS_OUT_FREE_TAIL = 8'hdc;
  localparam logic [7:0] OFS_OUT_POST_HEAD = 8'he0;
  localparam logic [7:0] OFS_OUT_POST_TAIL = 8'he4;
  localparam logic [7:0] OFS_CONTROL = 8'he8;

  localparam int OUT_POST_BIT = 3;
  localparam int CFG_ENABLE = 0;
  localparam int CFG_SIZE_LO = 1;
  localparam int CFG_SIZE_HI = 5;
  localparam int CTRL_DECODE = 0;
  localparam int CTRL_SPACE = 1;
  localparam int CTRL_PF_OUT = 2;
  localparam int CTRL_PF_IN = 3;
  localparam int CTRL_IN_MASK = 4;
  localparam int CTRL_IN_STAT = 5;
  localparam int CTRL_OVF_MASK = 6;
  localparam int CTRL_OVF_STAT = 7;
  localparam int PTR_LO = 2;
  localparam int PTR_HI = 19;
  localparam int BASE_LO = 20;
  localparam int BASE_HI = 31;

  localparam logic [31:0] RESET_VALUE = 32'h00000000;
  localparam logic [31:0] ALL_ONES = 32'hffffffff;
  localparam int CMD_FIFO_DEPTH = 8;

  localparam logic [4:0] SIZE_4K = 5'h01;
  localparam logic [4:0] SIZE_8K = 5'h02;
  localparam logic [4:0] SIZE_16K = 5'h04;
  localparam logic [4:0] SIZE_32K = 5'h08;
  localparam logic [4:0] SIZE_64K = 5'h10;
  localparam logic [17:0] MASK_4K = 18'h00fff;
  localparam logic [17:0] MASK_8K = 18'h01fff;
  localparam logic [17:0] MASK_16K = 18'h03fff;
  localparam logic [17:0] MASK_32K = 18'h07fff;
  localparam logic [17:0] MASK_64K = 18'h0ffff;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_IN_POST_WR = 3'b001,
    OP_OUT_FREE_WR = 3'b010,
    OP_IN_FREE_RD = 3'b011,
    OP_OUT_POST_RD = 3'b100
  } pmqu_op_e;

  typedef struct packed {
    logic write;
    logic spaceSel;
    logic [31:0] addr;
    logic [31:0] data;
  } pmqu_mem_cmd_s;

  localparam int CMD_WIDTH = 66;

endpackage

// ==== verif/pmqu_mem_model.sv ====
// Purpose: Local memory behind the queue unit's command port.
// Assumes: One operation in flight; random accept and finish delays.
// Notes: mem and lastSpace are read by the bench.
`timescale 1ns/1ns
`default_nettype none
module pmqu_mem_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic memReq,
  output logic memReady,
  input wire pmqu_pkg::pmqu_mem_cmd_s memCmd,
  output logic memDone,
  output logic [31:0] memRdata
);
  logic [31:0] mem [logic [31:0]];
  pmqu_pkg::pmqu_mem_cmd_s cur;
  logic busy;
  logic lastSpace;
  int delay;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      memReady <= 1'b0;
      memDone <= 1'b0;
      memRdata <= 32'h5aa5c33c;
      busy <= 1'b0;
      lastSpace <= 1'b0;
      delay <= 0;
    end else begin
      memDone <= 1'b0;
      // Data line toggles outside completions so stale words never look valid
      memRdata <= ~memRdata;
      memReady <= !busy && !(memReq && memReady) && $urandom_range(1, 0) == 1;
      if (memReq && memReady) begin
        cur <= memCmd;
        lastSpace <= memCmd.spaceSel;
        busy <= 1'b1;
        delay <= $urandom_range(6, 3);
      end else if (busy && delay > 0) begin
        delay <= delay - 1;
      end else if (busy) begin
        busy <= 1'b0;
        memDone <= 1'b1;
        if (cur.write) mem[cur.addr] = cur.data;
        else memRdata <= mem.exists(cur.addr) ? mem[cur.addr] : ~memRdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/pmqu_unit_monitor.sv ====
// Purpose: Port-level checks of the queue unit.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every pmqu_unit instance.
`timescale 1ns/1ns
`default_nettype none
module pmqu_unit_monitor (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regAck,
  input wire logic regRetry,
  input wire logic [31:0] regRdata,
  input wire logic memReq,
  input wire logic memReady,
  input wire pmqu_pkg::pmqu_mem_cmd_s memCmd,
  input wire logic memDone,
  input wire logic [31:0] memRdata,
  input wire logic pciIrq,
  input wire logic localIrq,
  input wire logic localSystemErrorIrq,
  input wire logic portDecodeEnable,
  input wire logic pciBaseRegionZeroRemap
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  logic wrCtrl;
  logic portReq;
  assign wrCtrl = regReq && regWrite && regAddr == pmqu_pkg::OFS_CONTROL;
  assign portReq = regReq && regAddr[7:3] == 5'h08;
  a_answer_once: assert property (regReq |=> regAck ^ regRetry)
    else $error("access not answered exactly once");
  a_no_stray: assert property ((regAck || regRetry) |-> $past(regReq))
    else $error("answer without request");
  a_retry_pending: assert property ((portReq && regWrite) ##1 (regAck && memReq) ##1 portReq |=> regRetry)
    else $error("port access not retried during update");
  a_cmd_hold: assert property (memReq && !memReady |=> memReq && $stable(memCmd))
    else $error("memory command changed before taken");
  a_cmd_aligned: assert property (memReq |-> memCmd.addr[1:0] == 2'h0)
    else $error("memory address not word aligned");
  a_pci_mask: assert property (regReq && regWrite && regAddr == pmqu_pkg::OFS_OUT_POST_MASK && regWdata[3] |-> ##[1:3] !pciIrq)
    else $error("masked outbound post interrupt still high");
  a_in_mask: assert property (wrCtrl && regWdata[4] |-> ##[1:3] !localIrq)
    else $error("masked inbound post interrupt still high");
  a_ovf_mask: assert property (wrCtrl && regWdata[6] |-> ##[1:3] !localSystemErrorIrq)
    else $error("masked overflow interrupt still high");
  a_decode_pair: assert property (wrCtrl |-> ##2 (portDecodeEnable == $past(regWdata[0], 2) &&
    pciBaseRegionZeroRemap == portDecodeEnable))
    else $error("decode outputs disagree");
  c_port_write: cover property (portReq && regWrite ##1 regAck);
  c_retry: cover property (portReq ##1 regRetry);
  c_overflow: cover property ($rose(localSystemErrorIrq));
endmodule
bind pmqu_unit pmqu_unit_monitor u_mon (.sys_clk, .resetn, .regReq, .regWrite, .regAddr,
  .regWdata, .regAck, .regRetry, .regRdata, .memReq, .memReady, .memCmd, .memDone,
  .memRdata, .pciIrq, .localIrq, .localSystemErrorIrq, .portDecodeEnable,
  .pciBaseRegionZeroRemap);
`default_nettype wire

// ==== verif/pmqu_unit_tb.sv ====
// Purpose: Self-checking bench of the queue unit.
// Assumes: Memory model on the command port, seed 21.
// Notes: Every FIFO size code is run once, with wrap and full cases.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got=%h exp=%h", $time, (a), (e)); end end
module pmqu_unit_tb;
  logic sys_clk, resetn, regReq, regWrite, regAck, regRetry;
  logic memReq, memReady, memDone, pciIrq, localIrq, localSystemErrorIrq;
  logic portDecodeEnable, pciBaseRegionZeroRemap;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, memRdata;
  pmqu_pkg::pmqu_mem_cmd_s memCmd;
  int n_mismatch = 0;
  int cmp_count = 0;
  pmqu_unit DUT (.sys_clk, .resetn, .regReq, .regWrite, .regAddr, .regWdata, .regAck,
    .regRetry, .regRdata, .memReq, .memReady, .memCmd, .memDone, .memRdata, .pciIrq,
    .localIrq, .localSystemErrorIrq, .portDecodeEnable, .pciBaseRegionZeroRemap);
  pmqu_mem_model mm (.sys_clk, .resetn, .memReq, .memReady, .memCmd, .memDone, .memRdata);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic rt);
    @(posedge sys_clk);
    regReq <= 1'b1;
    regWrite <= w;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regReq <= 1'b0;
    #1;
    r = regRdata;
    rt = regRetry;
    `CHK(regAck ^ regRetry, 1'b1)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic rt;
    acc(1'b1, a, d, r, rt);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic rt;
    acc(1'b0, a, 32'h0, r, rt);
    `CHK(r, e)
  endtask
  // Waits until the memory side has gone quiet, bounded
  task automatic idle();
    int i;
    repeat (4) @(posedge sys_clk);
    #1;
    for (i = 0; i < 100 && (memReq || mm.busy); i++) begin
      @(posedge sys_clk);
      #1;
    end
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic port(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    logic rt;
    int i;
    rt = 1'b1;
    for (i = 0; i < 100 && rt; i++) acc(w, a, d, r, rt);
    `CHK(rt, 1'b0)
    idle();
  endtask
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial begin
    logic [31:0] r, b, s, c, v;
    logic [31:0] p [8];
    logic rt;
    int k, j;
    resetn = 1'b0;
    regReq = 1'b0;
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    void'($urandom(21));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    for (k = 0; k < 15; k++) rd(k < 4 ? 8'(8'h30 + 4 * k + (k / 2) * 8) : 8'(8'hb0 + 4 * k), 32'h0);
    rd(8'h00, 32'h0);
    wr(pmqu_pkg::OFS_CONTROL, 32'h1);
    acc(1'b1, pmqu_pkg::OFS_IN_PORT, 32'h1234, r, rt);
    `CHK(memReq, 1'b0)
    rd(pmqu_pkg::OFS_IN_PORT, pmqu_pkg::ALL_ONES);
    rd(pmqu_pkg::OFS_OUT_PORT, pmqu_pkg::ALL_ONES);
    idle();
    `CHK(portDecodeEnable, 1'b1)
    `CHK(pciBaseRegionZeroRemap, 1'b1)
    for (k = 0; k < 5; k++) begin
      s = 32'h4000 << k;
      b = $urandom() & 32'hfff00000;
      c = {30'h0, k[0], 1'b1};
      p = '{32'h0, 32'h0, 2 * s - 4, 2 * s - 4, 4 * s - 8, 3 * s, 2 * s, 2 * s};
      wr(pmqu_pkg::OFS_CONFIG, 32'h0);
      wr(pmqu_pkg::OFS_BASE, b);
      for (j = 0; j < 8; j++) wr(8'(8'hc8 + 4 * j), p[j]);
      wr(pmqu_pkg::OFS_CONTROL, c);
      wr(pmqu_pkg::OFS_OUT_POST_MASK, 32'h0);
      wr(pmqu_pkg::OFS_CONFIG, {26'h0, 5'(1 << k), 1'b1});
      port(1'b0, pmqu_pkg::OFS_IN_PORT, 32'h0, r);
      `CHK(r, pmqu_pkg::ALL_ONES)
      port(1'b0, pmqu_pkg::OFS_OUT_PORT, 32'h0, r);
      `CHK(r, pmqu_pkg::ALL_ONES)
      `CHK(localIrq, 1'b0)
      v = $urandom();
      acc(1'b1, pmqu_pkg::OFS_IN_PORT, v, r, rt);
      acc(1'b0, pmqu_pkg::OFS_IN_PORT, 32'h0, r, rt);
      `CHK(rt, 1'b1)
      idle();
      `CHK(mm.mem[b + 2 * s - 4], v)
      `CHK(mm.lastSpace, k[0])
      rd(pmqu_pkg::OFS_IN_POST_HEAD, b | s);
      `CHK(localIrq, 1'b1)
      v = $urandom();
      port(1'b1, pmqu_pkg::OFS_OUT_PORT, v, r);
      `CHK(mm.mem[b + 4 * s - 8], v)
      rd(pmqu_pkg::OFS_OUT_FREE_HEAD, b | (4 * s - 4));
      `CHK(localSystemErrorIrq, 1'b1)
      rd(pmqu_pkg::OFS_CONTROL, c | 32'ha0);
      wr(pmqu_pkg::OFS_CONTROL, c | 32'h90);
      idle();
      `CHK(localIrq, 1'b0)
      rd(pmqu_pkg::OFS_CONTROL, c | 32'h30);
      `CHK(localSystemErrorIrq, 1'b0)
      v = $urandom();
      mm.mem[b + 2 * s] = v;
      wr(pmqu_pkg::OFS_OUT_POST_HEAD, 2 * s + 4);
      wr(pmqu_pkg::OFS_OUT_POST_MASK, 32'h8);
      idle();
      `CHK(pciIrq, 1'b0)
      rd(pmqu_pkg::OFS_OUT_POST_STATUS, 32'h8);
      wr(pmqu_pkg::OFS_CONTROL, c | 32'h4);
      wr(pmqu_pkg::OFS_OUT_POST_MASK, 32'h0);
      idle();
      `CHK(pciIrq, 1'b1)
      port(1'b0, pmqu_pkg::OFS_OUT_PORT, 32'h0, r);
      `CHK(r, v)
      rd(pmqu_pkg::OFS_OUT_POST_TAIL, b | (2 * s + 4));
      `CHK(pciIrq, 1'b0)
      v = $urandom();
      mm.mem[b] = v;
      wr(pmqu_pkg::OFS_IN_FREE_HEAD, 32'h4);
      wr(pmqu_pkg::OFS_CONTROL, c | 32'h18);
      idle();
      acc(1'b0, pmqu_pkg::OFS_IN_PORT, 32'h0, r, rt);
      `CHK(rt, 1'b0)
      `CHK(r, v)
      idle();
      rd(pmqu_pkg::OFS_IN_FREE_TAIL, b | 32'h4);
    end
    summarize();
  end
endmodule
`default_nettype wire
